// ---- core/csaa_core.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Standalone read loads entry into accumulator.
// - Direct read replies value, accumulator untouched.
// - Persistence select; default volatile only.
// - Entry zero never persisted nor restored.
// - Read 0,255,0 restores entries 1..20.
// - Read n,255 restores entry n only.
// - Capture copies actual position into entry.
// - Accumulator copied into selected entry.
// - Value don't-care; success replies status 100.
// - Calculation result written back to accumulator.
// - Types 0,1,2: add, subtract, multiply.
// - Types 3,4: divide, remainder.
// - Types 5,6,7: and, or, xor.
// - Type 8 inverts second register.
// - Type 9 loads, type 10 swaps.
module csaa_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host byte stream (direct mode)
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready_q,
  // Stored program command port (standalone mode)
  input wire logic prog_valid,
  input wire logic [7:0] prog_instr,
  input wire logic [7:0] prog_type,
  input wire logic [7:0] prog_motor,
  input wire logic [31:0] prog_value,
  output logic prog_ready_q,
  // Reply to the host
  output logic reply_valid_q,
  output logic [7:0] reply_status_q,
  output logic [7:0] reply_instr_q,
  output logic [31:0] reply_value_q,
  // Axis and configuration
  input wire logic [31:0] actual_pos,
  input wire logic persist_sel,
  // Working registers
  output logic [31:0] accu_q,
  output logic [31:0] xreg_q,
  // Nonvolatile store handshake
  output logic nv_req_q,
  output logic nv_we_q,
  output logic [4:0] nv_addr_q,
  output logic [31:0] nv_wdata_q,
  input wire logic nv_ack,
  input wire logic [31:0] nv_rdata
);
  import csaa_pkg::*;

  // ==========================================================
  // State
  csaa_state_type state_q, state_d;
  logic [31:0] table_q [COORD_COUNT];
  logic [31:0] table_d [COORD_COUNT];
  logic [7:0] fbuf_q [FRAME_LEN-1];
  logic [7:0] fbuf_d [FRAME_LEN-1];
  logic [3:0] fcnt_q, fcnt_d;
  logic [7:0] fsum_q, fsum_d;
  logic [7:0] c_ins_q, c_ins_d, c_typ_q, c_typ_d, c_mot_q, c_mot_d;
  logic [31:0] c_val_q, c_val_d;
  logic direct_q, direct_d;
  logic [4:0] idx_q, idx_d, last_q, last_d;
  logic rx_ready_d, prog_ready_d, reply_valid_d;
  logic [7:0] reply_status_d, reply_instr_d;
  logic [31:0] reply_value_d, accu_d, xreg_d;
  logic nv_req_d, nv_we_d;
  logic [4:0] nv_addr_d;
  logic [31:0] nv_wdata_d;
  logic [4:0] sel;

  // Signed divide; a zero divisor leaves the accumulator as it was,
  // since there is no trap to raise from here.
  function automatic logic [31:0] div_op(input logic [31:0] a,
                                         input logic [31:0] b,
                                         input logic rem);
    if (b == RESET_WORD) begin
      div_op = a;
    end else if (rem) begin
      div_op = $signed(a) % $signed(b);
    end else begin
      div_op = $signed(a) / $signed(b);
    end
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_d = state_q;
    table_d = table_q;
    fbuf_d = fbuf_q;
    fcnt_d = fcnt_q;
    fsum_d = fsum_q;
    c_ins_d = c_ins_q;
    c_typ_d = c_typ_q;
    c_mot_d = c_mot_q;
    c_val_d = c_val_q;
    direct_d = direct_q;
    idx_d = idx_q;
    last_d = last_q;
    reply_valid_d = 1'b0;
    reply_status_d = reply_status_q;
    reply_instr_d = reply_instr_q;
    reply_value_d = reply_value_q;
    accu_d = accu_q;
    xreg_d = xreg_q;
    nv_req_d = nv_req_q && !nv_ack;
    nv_we_d = nv_we_q;
    nv_addr_d = nv_addr_q;
    nv_wdata_d = nv_wdata_q;
    sel = c_typ_q[4:0];
    case (state_q)
      CSAA_BOOT: begin
        if (persist_sel) begin
          idx_d = COORD_FIRST_NV;
          last_d = COORD_LAST;
          nv_req_d = 1'b1;
          nv_we_d = 1'b0;
          nv_addr_d = COORD_FIRST_NV;
          direct_d = 1'b0;
          state_d = CSAA_NV_READ;
        end else begin
          state_d = CSAA_IDLE;
        end
      end
      CSAA_IDLE: begin
        if (rx_valid && rx_ready_q) begin
          if (fcnt_q == FRAME_SUM_IDX) begin
            fcnt_d = RESET_FCNT;
            fsum_d = RESET_BYTE;
            if (fbuf_q[0] == MODULE_ADDR) begin
              c_ins_d = fbuf_q[1];
              c_typ_d = fbuf_q[2];
              c_mot_d = fbuf_q[3];
              c_val_d = {fbuf_q[4], fbuf_q[5], fbuf_q[6], fbuf_q[7]};
              direct_d = 1'b1;
              reply_instr_d = fbuf_q[1];
              if (fsum_q == rx_byte) begin
                state_d = CSAA_EXEC;
              end else begin
                reply_status_d = ST_BAD_SUM;
                reply_value_d = RESET_WORD;
                state_d = CSAA_DONE;
              end
            end
          end else begin
            fbuf_d[fcnt_q[2:0]] = rx_byte;
            fsum_d = 8'(fsum_q + rx_byte);
            fcnt_d = 4'(fcnt_q + 4'h1);
          end
        end else if (prog_valid && prog_ready_q) begin
          c_ins_d = prog_instr;
          c_typ_d = prog_type;
          c_mot_d = prog_motor;
          c_val_d = prog_value;
          direct_d = 1'b0;
          reply_instr_d = prog_instr;
          state_d = CSAA_EXEC;
        end
      end
      CSAA_EXEC: begin
        reply_status_d = ST_OK;
        reply_value_d = RESET_WORD;
        state_d = CSAA_DONE;
        case (c_ins_q)
          INS_COORD_READ, INS_COORD_SET, INS_COORD_CAPTURE,
          INS_ACCU_TO_COORD: begin
            if (c_typ_q > {3'h0, COORD_LAST}) begin
              reply_status_d = ST_BAD_TYPE;
            end else if (c_mot_q == MOTOR_NV &&
                         (c_ins_q == INS_COORD_READ ||
                          c_ins_q == INS_COORD_SET)) begin
              // Entry zero is skipped in both bulk copies.
              idx_d = (sel == 5'h00) ? COORD_FIRST_NV : sel;
              last_d = (sel == 5'h00) ? COORD_LAST : sel;
              nv_req_d = 1'b1;
              nv_addr_d = idx_d;
              nv_wdata_d = table_q[idx_d];
              nv_we_d = (c_ins_q == INS_COORD_SET);
              state_d = nv_we_d ? CSAA_NV_WRITE : CSAA_NV_READ;
            end else if (c_mot_q != MOTOR_AXIS) begin
              reply_status_d = ST_BAD_VALUE;
            end else if (c_ins_q == INS_COORD_READ) begin
              if (direct_q) begin
                reply_value_d = table_q[sel];
              end else begin
                accu_d = table_q[sel];
              end
            end else begin
              if (c_ins_q == INS_COORD_SET) begin
                table_d[sel] = c_val_q;
              end else if (c_ins_q == INS_COORD_CAPTURE) begin
                table_d[sel] = actual_pos;
                reply_value_d = actual_pos;
              end else begin
                table_d[sel] = accu_q;
              end
              // Persisted copies follow every write except entry zero.
              if (persist_sel && sel != 5'h00) begin
                idx_d = sel;
                last_d = sel;
                nv_req_d = 1'b1;
                nv_we_d = 1'b1;
                nv_addr_d = sel;
                nv_wdata_d = table_d[sel];
                state_d = CSAA_NV_WRITE;
              end
            end
          end
          INS_WITH_IMMEDIATE_A_SECOND: begin
            case (c_typ_q)
              OP_ADD: accu_d = 32'(accu_q + xreg_q);
              OP_SUB: accu_d = 32'(accu_q - xreg_q);
              OP_MUL: accu_d = 32'($signed(accu_q) * $signed(xreg_q));
              OP_DIV: accu_d = div_op(accu_q, xreg_q, 1'b0);
              OP_MOD: accu_d = div_op(accu_q, xreg_q, 1'b1);
              OP_AND: accu_d = accu_q & xreg_q;
              OP_OR: accu_d = accu_q | xreg_q;
              OP_XOR: accu_d = accu_q ^ xreg_q;
              OP_NOT: xreg_d = ~xreg_q;
              OP_LOAD: xreg_d = accu_q;
              OP_SWAP: begin
                accu_d = xreg_q;
                xreg_d = accu_q;
              end
              default: reply_status_d = ST_BAD_TYPE;
            endcase
          end
          default: reply_status_d = ST_BAD_INSTR;
        endcase
      end
      CSAA_NV_READ: begin
        if (nv_ack) begin
          table_d[idx_q] = nv_rdata;
          if (idx_q == last_q) begin
            state_d = direct_q ? CSAA_DONE : CSAA_IDLE;
          end else begin
            idx_d = 5'(idx_q + 5'h01);
            nv_req_d = 1'b1;
            nv_addr_d = idx_d;
          end
        end
      end
      CSAA_NV_WRITE: begin
        if (nv_ack) begin
          if (idx_q == last_q) begin
            state_d = CSAA_DONE;
          end else begin
            idx_d = 5'(idx_q + 5'h01);
            nv_req_d = 1'b1;
            nv_addr_d = idx_d;
            nv_wdata_d = table_q[idx_d];
          end
        end
      end
      CSAA_DONE: begin
        reply_valid_d = direct_q;
        state_d = CSAA_IDLE;
      end
      default: state_d = CSAA_IDLE;
    endcase
    rx_ready_d = (state_d == CSAA_IDLE);
    prog_ready_d = (state_d == CSAA_IDLE) && (fcnt_d == RESET_FCNT);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= CSAA_BOOT;
      for (int i = 0; i < COORD_COUNT; i++) begin
        table_q[i] <= RESET_WORD;
      end
      for (int i = 0; i < FRAME_LEN - 1; i++) begin
        fbuf_q[i] <= RESET_BYTE;
      end
      fcnt_q <= RESET_FCNT;
      fsum_q <= RESET_BYTE;
      c_ins_q <= RESET_BYTE;
      c_typ_q <= RESET_BYTE;
      c_mot_q <= RESET_BYTE;
      c_val_q <= RESET_WORD;
      direct_q <= 1'b0;
      idx_q <= 5'h00;
      last_q <= 5'h00;
      rx_ready_q <= 1'b0;
      prog_ready_q <= 1'b0;
      reply_valid_q <= 1'b0;
      reply_status_q <= RESET_BYTE;
      reply_instr_q <= RESET_BYTE;
      reply_value_q <= RESET_WORD;
      accu_q <= RESET_WORD;
      xreg_q <= RESET_WORD;
      nv_req_q <= 1'b0;
      nv_we_q <= 1'b0;
      nv_addr_q <= 5'h00;
      nv_wdata_q <= RESET_WORD;
    end else begin
      state_q <= state_d;
      table_q <= table_d;
      fbuf_q <= fbuf_d;
      fcnt_q <= fcnt_d;
      fsum_q <= fsum_d;
      c_ins_q <= c_ins_d;
      c_typ_q <= c_typ_d;
      c_mot_q <= c_mot_d;
      c_val_q <= c_val_d;
      direct_q <= direct_d;
      idx_q <= idx_d;
      last_q <= last_d;
      rx_ready_q <= rx_ready_d;
      prog_ready_q <= prog_ready_d;
      reply_valid_q <= reply_valid_d;
      reply_status_q <= reply_status_d;
      reply_instr_q <= reply_instr_d;
      reply_value_q <= reply_value_d;
      accu_q <= accu_d;
      xreg_q <= xreg_d;
      nv_req_q <= nv_req_d;
      nv_we_q <= nv_we_d;
      nv_addr_q <= nv_addr_d;
      nv_wdata_q <= nv_wdata_d;
    end
  end

endmodule

// ---- core/csaa_pkg.sv ----
package csaa_pkg;

  // ==========================================================
  // Command frame layout
  localparam int unsigned FRAME_LEN = 9;
  localparam logic [3:0] FRAME_SUM_IDX = 4'h8;
  localparam logic [7:0] MODULE_ADDR = 8'h01;

  // ==========================================================
  // Instruction numbers
  localparam logic [7:0] INS_COORD_SET = 8'h1E;
  localparam logic [7:0] INS_COORD_READ = 8'h1F;
  localparam logic [7:0] INS_COORD_CAPTURE = 8'h20;
  localparam logic [7:0] INS_WITH_IMMEDIATE_A_SECOND = 8'h21;
  localparam logic [7:0] INS_ACCU_TO_COORD = 8'h27;

  // ==========================================================
  // Operation types of the second-register calculation
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_MUL = 8'h02;
  localparam logic [7:0] OP_DIV = 8'h03;
  localparam logic [7:0] OP_MOD = 8'h04;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  localparam logic [7:0] OP_SWAP = 8'h0A;

  // ==========================================================
  // Coordinate table
  localparam int unsigned COORD_COUNT = 21;
  localparam logic [4:0] COORD_FIRST_NV = 5'h01;
  localparam logic [4:0] COORD_LAST = 5'h14;
  localparam logic [7:0] MOTOR_NV = 8'hFF;
  localparam logic [7:0] MOTOR_AXIS = 8'h00;

  // ==========================================================
  // Reply status codes
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_INSTR = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;

  // ==========================================================
  // Values after reset
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_FCNT = 4'h0;

  typedef enum {
    CSAA_BOOT,
    CSAA_IDLE,
    CSAA_EXEC,
    CSAA_NV_READ,
    CSAA_NV_WRITE,
    CSAA_DONE
  } csaa_state_type;

endpackage

// ---- verification/coordinate_store_and_accu_alu_bench.sv ----
`timescale 1ns/1ps
module coordinate_store_and_accu_alu_bench;
  import csaa_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid = 1'b0;
  logic persist_sel = 1'b1;
  logic prog_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00, p_ins = 8'h00, p_typ = 8'h00, p_mot = 8'h00;
  logic [31:0] p_val = 32'h0, actual_pos = 32'h0, ea, ex, r1, r2, r3;
  logic rx_ready_q, prog_ready_q, reply_valid_q, nv_req_q, nv_we_q, nv_ack;
  logic [7:0] reply_status_q, reply_instr_q;
  logic [31:0] reply_value_q, accu_q, xreg_q, nv_wdata_q, nv_rdata;
  logic [4:0] nv_addr_q;
  logic [15:0] seed = 16'h005E;
  logic [48:0] exp_q [$];
  logic [48:0] e;
  int n_fail = 0, cmp_count = 0, cyc = 0;

  csaa_core i_dut (.mclk, .rst, .rx_valid, .rx_byte, .rx_ready_q, .prog_valid,
    .prog_instr(p_ins), .prog_type(p_typ), .prog_motor(p_mot),
    .prog_value(p_val), .prog_ready_q, .reply_valid_q, .reply_status_q,
    .reply_instr_q, .reply_value_q, .actual_pos, .persist_sel, .accu_q,
    .xreg_q, .nv_req_q, .nv_we_q, .nv_addr_q, .nv_wdata_q, .nv_ack, .nv_rdata);
  csaa_nv_model i_nv (.mclk, .rst, .nv_req(nv_req_q), .nv_we(nv_we_q),
    .nv_addr(nv_addr_q), .nv_wdata(nv_wdata_q), .nv_ack, .nv_rdata);

  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] nv(input int i);
    return 32'hA5000000 | 32'(i);
  endfunction
  task automatic rnd(output logic [31:0] v);
    seed = lfsr(seed);
    v[31:16] = seed;
    seed = lfsr(seed);
    v[15:0] = seed;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Waiting a few edges first lets the reply pulse of a frame land.
  task automatic idle();
    repeat (5) @(posedge mclk);
    #2;
    while (!(rx_ready_q === 1'b1 && prog_ready_q === 1'b1 && nv_req_q === 1'b0))
      @(posedge mclk) #2;
  endtask
  task automatic frame(input logic [7:0] adr, ins, typ, mot,
      input logic [31:0] val, input logic [7:0] st, input logic [31:0] rv,
      input logic cv, bad);
    logic [7:0] b [9];
    b = '{adr, ins, typ, mot, val[31:24], val[23:16], val[15:8], val[7:0],
      8'h00};
    for (int i = 0; i < 8; i++) b[8] += b[i];
    b[8] += {7'h00, bad};
    if (adr == MODULE_ADDR) exp_q.push_back({cv, ins, st, rv});
    for (int i = 0; i < 9; i++) begin
      rx_valid = 1'b1;
      rx_byte = b[i];
      while (rx_ready_q !== 1'b1) @(posedge mclk) #2;
      @(posedge mclk) #2;
    end
    rx_valid = 1'b0;
    idle();
  endtask
  task automatic rd(input logic [7:0] n, input logic [31:0] v);
    frame(MODULE_ADDR, INS_COORD_READ, n, MOTOR_AXIS, 32'h0, ST_OK, v, 1, 0);
  endtask
  task automatic cmd(input logic [7:0] ins, n, mot, input logic [31:0] v);
    frame(MODULE_ADDR, ins, n, mot, v, ST_OK, 32'h0, 1'b0, 1'b0);
  endtask
  // Commands the block must turn away, each with its own status code.
  task automatic refused(input logic [7:0] ins, typ, mot, st);
    frame(MODULE_ADDR, ins, typ, mot, 32'h0, st, 32'h0, 1'b0, 1'b0);
  endtask
  task automatic prog(input logic [7:0] ins, typ);
    prog_valid = 1'b1;
    p_ins = ins;
    p_typ = typ;
    rnd(p_val);
    while (prog_ready_q !== 1'b1) @(posedge mclk) #2;
    @(posedge mclk) #2;
    prog_valid = 1'b0;
    idle();
  endtask
  task automatic alu(input logic [7:0] op);
    logic [31:0] a, x;
    a = ea;
    x = ex;
    case (op)
      OP_ADD: ea = a + x;
      OP_SUB: ea = a - x;
      OP_MUL: ea = a * x;
      OP_DIV: ea = $signed(a) / $signed(x);
      OP_MOD: ea = $signed(a) % $signed(x);
      OP_AND: ea = a & x;
      OP_OR: ea = a | x;
      OP_XOR: ea = a ^ x;
      OP_NOT: ex = ~x;
      OP_LOAD: ex = a;
      default: {ea, ex} = {x, a};
    endcase
    prog(INS_WITH_IMMEDIATE_A_SECOND, op);
    check("accu", accu_q, ea);
    check("xreg", xreg_q, ex);
  endtask

  // ==========================================================
  // Reply monitor
  always @(posedge mclk) begin
    if (reply_valid_q === 1'b1) begin
      if (exp_q.size() == 0) check("reply_count", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        check("status", {24'h0, reply_status_q}, {24'h0, e[39:32]});
        check("instr", {24'h0, reply_instr_q}, {24'h0, e[47:40]});
        if (e[48]) check("value", reply_value_q, e[31:0]);
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    #2 rst = 1'b0;
    idle();
    for (int i = 0; i < 21; i += 5) rd(8'(i), (i == 0) ? 32'h0 : nv(i));
    rnd(r1);
    rnd(r2);
    rnd(r3);
    cmd(INS_COORD_SET, 8'h07, MOTOR_AXIS, r1);
    persist_sel = 1'b0;
    cmd(INS_COORD_SET, 8'h07, MOTOR_AXIS, r2);
    cmd(INS_COORD_SET, 8'h03, MOTOR_AXIS, r2);
    rd(8'h07, r2);
    cmd(INS_COORD_READ, 8'h07, MOTOR_NV, 32'h0);
    rd(8'h07, r1);
    rd(8'h03, r2);
    cmd(INS_COORD_READ, 8'h00, MOTOR_NV, 32'h0);
    rd(8'h03, nv(3));
    actual_pos = r3;
    frame(MODULE_ADDR, INS_COORD_CAPTURE, 8'h04, MOTOR_AXIS, r1, ST_OK, r3, 1, 0);
    rd(8'h04, r3);
    prog(INS_COORD_READ, 8'h05);
    ea = nv(5);
    alu(OP_LOAD);
    prog(INS_COORD_READ, 8'h04);
    ea = r3;
    check("accu_read", accu_q, ea);
    rd(8'h05, nv(5));
    check("accu_kept", accu_q, ea);
    for (int op = 0; op < 11; op++) alu(8'(op));
    prog(INS_ACCU_TO_COORD, 8'h09);
    rd(8'h09, ea);
    cmd(INS_ACCU_TO_COORD, 8'h02, MOTOR_AXIS, 32'h0);
    rd(8'h02, ea);
    // Bulk copy to the store, then a single-entry restore brings it back.
    cmd(INS_COORD_SET, 8'h03, MOTOR_AXIS, r1);
    cmd(INS_COORD_SET, 8'h00, MOTOR_NV, 32'h0);
    cmd(INS_COORD_SET, 8'h03, MOTOR_AXIS, r2);
    cmd(INS_COORD_READ, 8'h03, MOTOR_NV, 32'h0);
    rd(8'h03, r1);
    refused(8'h7F, 8'h00, MOTOR_AXIS, ST_BAD_INSTR);
    refused(INS_COORD_READ, 8'h15, MOTOR_AXIS, ST_BAD_TYPE);
    refused(INS_COORD_CAPTURE, 8'h04, 8'h01, ST_BAD_VALUE);
    refused(INS_WITH_IMMEDIATE_A_SECOND, 8'h0B, MOTOR_AXIS, ST_BAD_TYPE);
    frame(8'h02, INS_COORD_READ, 8'h02, MOTOR_AXIS, 32'h0, ST_OK, 0, 0, 0);
    frame(MODULE_ADDR, INS_COORD_READ, 8'h02, MOTOR_AXIS, 0, ST_BAD_SUM, 0, 0, 1);
    check("pending", 32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule

// ---- verification/csaa_core_asserts.sv ----
`timescale 1ns/1ps
module csaa_core_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Observed ports
  input wire logic rx_ready_q,
  input wire logic prog_valid,
  input wire logic [7:0] prog_instr,
  input wire logic [7:0] prog_type,
  input wire logic prog_ready_q,
  input wire logic reply_valid_q,
  input wire logic [31:0] accu_q,
  input wire logic [31:0] xreg_q,
  input wire logic nv_req_q,
  input wire logic nv_we_q,
  input wire logic [4:0] nv_addr_q,
  input wire logic nv_ack
);
  import csaa_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic take;
  logic [31:0] a_q, a_d, x_q, x_d;
  assign take = prog_valid && prog_ready_q && prog_instr == INS_WITH_IMMEDIATE_A_SECOND;
  // Operands are frozen at the take edge, before the result overwrites them.
  always_comb begin
    a_d = take ? accu_q : a_q;
    x_d = take ? xreg_q : x_q;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_q <= 32'h00000000;
      x_q <= 32'h00000000;
    end else begin
      a_q <= a_d;
      x_q <= x_d;
    end
  end
  // ==========================================================
  // Properties
  a_nv_no_zero: assert property (nv_req_q |-> nv_addr_q != 5'h00)
    else $error("NV access to entry zero");
  a_nv_req_hold: assert property (nv_req_q && !nv_ack |=> nv_req_q &&
    $stable(nv_addr_q) && $stable(nv_we_q)) else $error("NV request moved");
  a_nv_ascend: assert property (nv_req_q && nv_ack ##1 nv_req_q |->
    nv_addr_q == $past(nv_addr_q) + 5'h01) else $error("NV index order");
  a_reply_pulse: assert property (reply_valid_q |=> !reply_valid_q)
    else $error("Reply longer than one cycle");
  a_reply_ready: assert property (reply_valid_q |-> rx_ready_q)
    else $error("Not ready with reply");
  a_prog_busy: assert property (prog_valid && prog_ready_q |=>
    !prog_ready_q [*2]) else $error("Program port ready too early");
  a_add_result: assert property (take && prog_type == OP_ADD |->
    ##[2:3] accu_q == a_q + x_q) else $error("Sum wrong");
  a_and_result: assert property (take && prog_type == OP_AND |->
    ##[2:3] accu_q == (a_q & x_q)) else $error("And wrong");
  a_not_invert: assert property (take && prog_type == OP_NOT |->
    ##[2:3] xreg_q == ~x_q) else $error("Invert wrong");
  a_swap_both: assert property (take && prog_type == OP_SWAP |->
    ##[2:3] accu_q == x_q && xreg_q == a_q) else $error("Swap wrong");
endmodule

bind csaa_core csaa_core_asserts i_chk (.mclk(mclk), .rst(rst),
  .rx_ready_q(rx_ready_q), .prog_valid(prog_valid), .prog_instr(prog_instr),
  .prog_type(prog_type), .prog_ready_q(prog_ready_q),
  .reply_valid_q(reply_valid_q), .accu_q(accu_q), .xreg_q(xreg_q),
  .nv_req_q(nv_req_q), .nv_we_q(nv_we_q), .nv_addr_q(nv_addr_q),
  .nv_ack(nv_ack));

// ---- verification/csaa_nv_model.sv ----
`timescale 1ns/1ps
// Nonvolatile store model. It answers after no wait and after three cycles in
// turn, and read data changes every cycle outside the acknowledge cycle.
module csaa_nv_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Store handshake
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [4:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  output logic nv_ack,
  output logic [31:0] nv_rdata
);
  logic [31:0] mem [0:20];
  logic [1:0] cnt;
  logic [1:0] slow;

  // Contents survive reset, as a real nonvolatile part would.
  initial for (int i = 0; i < 21; i++) mem[i] = 32'hA5000000 | 32'(i);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      nv_ack <= 1'b0;
      cnt <= 2'h0;
      slow <= 2'h0;
      nv_rdata <= 32'h5A5A5A5A;
    end else if (!nv_req || nv_ack) begin
      nv_ack <= 1'b0;
      cnt <= 2'h0;
      nv_rdata <= ~nv_rdata;
    end else if (cnt == slow) begin
      nv_ack <= 1'b1;
      slow <= slow ^ 2'h3;
      nv_rdata <= mem[nv_addr];
      if (nv_we) mem[nv_addr] <= nv_wdata;
    end else begin
      cnt <= cnt + 2'h1;
      nv_rdata <= ~nv_rdata;
    end
  end
endmodule
